// ### verilog/cafs_pkg.sv
`default_nettype none
package cafs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 16;
  localparam int THR_W  = 12;
  localparam int FILL_W = 4;
  localparam int NFLAG  = 8;
  localparam int CODE_W = 8;

  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LOW    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HIGH   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG2   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ISTAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IMASK  = 8'h14;

  localparam logic [THR_W-1:0]  RST_LOW   = 12'h800;
  localparam logic [THR_W-1:0]  RST_HIGH  = 12'h7FF;
  localparam logic [NFLAG-1:0]  RST_FLAGS = 8'h00;
  localparam logic [NFLAG-1:0]  RST_MASK  = 8'h00;

  localparam logic [CODE_W-1:0] CODE_SOFT = 8'h3C;
  localparam logic [CODE_W-1:0] CODE_HARD = 8'hFF;

  localparam logic [FILL_W-1:0] LOW_FILL  = 4'h0;
  localparam logic [FILL_W-1:0] HIGH_FILL = 4'hF;

  localparam int BIT_A_UNDER = 0;
  localparam int BIT_A_OVER  = 1;
  localparam int BIT_B_UNDER = 2;
  localparam int BIT_B_OVER  = 3;
  localparam int BIT_C_UNDER = 4;
  localparam int BIT_C_OVER  = 5;
  localparam int BIT_D_UNDER = 6;
  localparam int BIT_D_OVER  = 7;

  function automatic logic [RES_W-1:0] thr_low(input logic [THR_W-1:0] t);
    return {t, LOW_FILL};
  endfunction

  function automatic logic [RES_W-1:0] thr_high(input logic [THR_W-1:0] t);
    return {t, HIGH_FILL};
  endfunction
endpackage
`default_nettype wire

// ### verilog/cafs_chan_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module cafs_chan_cmp (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       result_valid,
  input  wire logic [cafs_pkg::RES_W-1:0] result,
  input  wire logic [cafs_pkg::THR_W-1:0] low_thr,
  input  wire logic [cafs_pkg::THR_W-1:0] high_thr,
  output logic                            under_q,
  output logic                            over_q
);
  import cafs_pkg::*;

  typedef struct packed {
    logic under;
    logic over;
  } cafs_cmp_t;

  cafs_cmp_t s_q;
  cafs_cmp_t s_d;

  always_comb begin
    s_d = '0;
    if (result_valid) begin
      s_d.under = result < thr_low(low_thr);
      s_d.over  = result > thr_high(high_thr);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign under_q = s_q.under;
  assign over_q  = s_q.over;
endmodule
`default_nettype wire

// ### verilog/cafs_top.sv
// Operation
// - Channel D result below the low threshold sets status bit 6.
// - Channel C result above the high threshold sets status bit 5.
// - Channel C result below the low threshold sets status bit 4.
// - Channel B result above the high threshold sets status bit 3.
// - Channel B result below the low threshold sets status bit 2.
// - Channel A result above the high threshold sets status bit 1.
// - Channel A result below the low threshold sets status bit 0.
// - Flags stay set until software reads the status register or writes a reset code to CFG2.
// - Flags read 1 while an alert is pending, are read-only, reset to 0.
// - Channel D result above the high threshold sets status bit 7.
// - Low threshold is the 12-bit field over four zero bits.
// - High threshold is the 12-bit field over four one bits.
// - Writing the soft-reset code to the reset field clears all flags.
`timescale 1ns/1ps
`default_nettype none
module cafs_top (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cafs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cafs_pkg::DATA_W-1:0] pwdata,
  output logic      [cafs_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        result_valid,
  input  wire logic [cafs_pkg::RES_W-1:0]  result_a,
  input  wire logic [cafs_pkg::RES_W-1:0]  result_b,
  input  wire logic [cafs_pkg::RES_W-1:0]  result_c,
  input  wire logic [cafs_pkg::RES_W-1:0]  result_d,
  output logic      [cafs_pkg::NFLAG-1:0]  alert_flags,
  output logic                             irq
);
  import cafs_pkg::*;

  typedef struct packed {
    logic [NFLAG-1:0]  flags;
    logic [THR_W-1:0]  low_thr;
    logic [THR_W-1:0]  high_thr;
    logic [NFLAG-1:0]  ista;
    logic [NFLAG-1:0]  imask;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } cafs_state_t;

  cafs_state_t s_q;
  cafs_state_t s_d;

  logic [NFLAG-1:0] ev;
  logic [RES_W-1:0] results [4];
  logic             acc;
  logic             wr;
  logic             rd;
  logic             rd_clr;
  logic             soft_clr;
  logic             hard_rst;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_STATUS) || (a == OFS_LOW) || (a == OFS_HIGH) ||
           (a == OFS_CFG2) || (a == OFS_ISTAT) || (a == OFS_IMASK);
  endfunction

  function automatic logic [DATA_W-1:0] widen8(input logic [NFLAG-1:0] v);
    return {{(DATA_W-NFLAG){1'b0}}, v};
  endfunction

  function automatic logic [DATA_W-1:0] widen12(input logic [THR_W-1:0] v);
    return {{(DATA_W-THR_W){1'b0}}, v};
  endfunction

  assign results[0] = result_a;
  assign results[1] = result_b;
  assign results[2] = result_c;
  assign results[3] = result_d;

  // Flag bit 2k is channel k under, bit 2k+1 is channel k over
  for (genvar k = 0; k < 4; k++) begin : g_chan
    cafs_chan_cmp u_cmp (
      .clock        (clock),
      .rst_n        (rst_n),
      .result_valid (result_valid),
      .result       (results[k]),
      .low_thr      (s_q.low_thr),
      .high_thr     (s_q.high_thr),
      .under_q      (ev[2*k]),
      .over_q       (ev[2*k+1])
    );
  end

  always_comb begin
    acc      = psel && penable && !s_q.pready;
    wr       = acc && pwrite;
    rd       = acc && !pwrite;
    rd_clr   = rd && (paddr == OFS_STATUS);
    hard_rst = wr && (paddr == OFS_CFG2) &&
               (pwdata[CODE_W-1:0] == CODE_HARD);
    soft_clr = hard_rst || (wr && (paddr == OFS_CFG2) &&
               (pwdata[CODE_W-1:0] == CODE_SOFT));

    s_d         = s_q;
    s_d.pready  = acc;
    s_d.pslverr = acc && !mapped(paddr);

    if (rd) begin
      unique case (paddr)
        OFS_STATUS: s_d.prdata = widen8(s_q.flags);
        OFS_LOW:    s_d.prdata = widen12(s_q.low_thr);
        OFS_HIGH:   s_d.prdata = widen12(s_q.high_thr);
        OFS_ISTAT:  s_d.prdata = widen8(s_q.ista);
        OFS_IMASK:  s_d.prdata = widen8(s_q.imask);
        default:    s_d.prdata = '0;
      endcase
    end

    if (wr && (paddr == OFS_LOW)) begin
      s_d.low_thr = pwdata[THR_W-1:0];
    end
    if (wr && (paddr == OFS_HIGH)) begin
      s_d.high_thr = pwdata[THR_W-1:0];
    end
    if (wr && (paddr == OFS_IMASK)) begin
      s_d.imask = pwdata[NFLAG-1:0];
    end
    if (wr && (paddr == OFS_ISTAT)) begin
      s_d.ista = s_q.ista & ~pwdata[NFLAG-1:0];
    end
    if (hard_rst) begin
      s_d.low_thr  = RST_LOW;
      s_d.high_thr = RST_HIGH;
      s_d.imask    = RST_MASK;
      s_d.ista     = RST_FLAGS;
    end

    // Clear by read or soft reset, then new crossings win
    if (rd_clr || soft_clr) begin
      s_d.flags = RST_FLAGS;
    end
    s_d.flags = s_d.flags | ev;
    s_d.ista  = s_d.ista | ev;
    s_d.irq   = |(s_d.ista & s_d.imask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.flags    <= RST_FLAGS;
      s_q.low_thr  <= RST_LOW;
      s_q.high_thr <= RST_HIGH;
      s_q.imask    <= RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign alert_flags = s_q.flags;
  assign irq         = s_q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_under(logic [RES_W-1:0] res);
    result_valid && (res < thr_low(s_q.low_thr));
  endsequence

  sequence s_over(logic [RES_W-1:0] res);
    result_valid && (res > thr_high(s_q.high_thr));
  endsequence

  property p_d_under;
    s_under(result_d) |-> ##2 alert_flags[BIT_D_UNDER];
  endproperty
  a_d_under: assert property (p_d_under)
    else $error("channel D under flag not set");

  property p_c_over;
    s_over(result_c) |-> ##2 alert_flags[BIT_C_OVER];
  endproperty
  a_c_over: assert property (p_c_over)
    else $error("channel C over flag not set");

  property p_c_under;
    s_under(result_c) |-> ##2 alert_flags[BIT_C_UNDER];
  endproperty
  a_c_under: assert property (p_c_under)
    else $error("channel C under flag not set");

  property p_b_over;
    s_over(result_b) |-> ##2 alert_flags[BIT_B_OVER];
  endproperty
  a_b_over: assert property (p_b_over)
    else $error("channel B over flag not set");

  property p_b_under;
    s_under(result_b) |-> ##2 alert_flags[BIT_B_UNDER];
  endproperty
  a_b_under: assert property (p_b_under)
    else $error("channel B under flag not set");

  property p_a_over;
    s_over(result_a) |-> ##2 alert_flags[BIT_A_OVER];
  endproperty
  a_a_over: assert property (p_a_over)
    else $error("channel A over flag not set");

  property p_a_under;
    s_under(result_a) |-> ##2 alert_flags[BIT_A_UNDER];
  endproperty
  a_a_under: assert property (p_a_under)
    else $error("channel A under flag not set");

  property p_d_over;
    s_over(result_d) |-> ##2 alert_flags[BIT_D_OVER];
  endproperty
  a_d_over: assert property (p_d_over)
    else $error("channel D over flag not set");

  property p_sticky;
    !rd_clr && !soft_clr |=>
      (alert_flags & $past(alert_flags)) == $past(alert_flags);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("alert flag dropped without a clear");

  property p_read_clear;
    rd_clr && (ev == '0) |=> alert_flags == RST_FLAGS;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flags");

  property p_set_wins;
    rd_clr && (ev != '0) |=> (alert_flags & $past(ev)) == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost during status read");

  property p_soft_clear;
    soft_clr && (ev == '0) |=> alert_flags == RST_FLAGS;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft reset did not clear flags");

  property p_irq_level;
    irq == |(s_q.ista & s_q.imask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status and mask");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");

  property p_flag_cause;
    (alert_flags & ~$past(alert_flags) & ~$past(ev)) == RST_FLAGS;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("alert flag set without a crossing");

  property p_status_data;
    rd_clr |=> prdata == widen8($past(alert_flags));
  endproperty
  a_status_data: assert property (p_status_data)
    else $error("status read returned wrong flags");

  property p_status_ro;
    wr && (paddr == OFS_STATUS) && (ev == '0) |=>
      alert_flags == $past(alert_flags);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("write to status changed the flags");

  property p_irq_event;
    !wr && ((ev & s_q.imask) != '0) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("unmasked crossing did not raise interrupt");

  property p_hard_reset;
    hard_rst |=> (s_q.low_thr == RST_LOW) && (s_q.high_thr == RST_HIGH) &&
      (s_q.imask == RST_MASK);
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset did not restore defaults");

  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr raised outside a response");
endmodule
`default_nettype wire

// ### verification/tb_channel_alert_flag_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_channel_alert_flag_status;
  import cafs_pkg::*;
  logic              clock, rst_n, psel, penable, pwrite, pready;
  logic              pslverr, irq, err, result_valid;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [RES_W-1:0]  res_a, res_b, res_c, res_d;
  logic [NFLAG-1:0]  alert_flags, mdl;
  logic [THR_W-1:0]  lo, hi;
  logic [31:0]       seed, r1, r2;
  int                num_errors, cmp_count, cyc;

  cafs_top dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_valid(result_valid), .result_a(res_a), .result_b(res_b),
    .result_c(res_c), .result_d(res_d), .alert_flags(alert_flags),
    .irq(irq));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [NFLAG-1:0] expect_f(
      input logic [RES_W-1:0] a, b, c, d);
    logic [RES_W-1:0] v [4];
    v = '{a, b, c, d};
    for (int k = 0; k < 4; k++) begin
      expect_f[2*k]   = v[k] < {lo, 4'h0};
      expect_f[2*k+1] = v[k] > {hi, 4'hF};
    end
  endfunction

  // Boundary values around the two thresholds
  function automatic logic [RES_W-1:0] bnd(input int i);
    case (i % 4)
      0:       bnd = {lo, 4'h0};
      1:       bnd = {lo, 4'h0} - 16'h0001;
      2:       bnd = {hi, 4'hF};
      default: bnd = {hi, 4'hF} + 16'h0001;
    endcase
  endfunction

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t read %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_fl(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t flags %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic rv);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (rv) result_valid <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    result_valid <= 1'b0;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic v, input logic [RES_W-1:0] a, b, c, d);
    @(posedge clock);
    result_valid <= v;
    res_a <= a;
    res_b <= b;
    res_c <= c;
    res_d <= d;
    if (v) mdl = mdl | expect_f(a, b, c, d);
    @(posedge clock);
    result_valid <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic rd_status();
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
    chk_rd(rd, {24'h0, mdl});
    mdl = '0;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    {psel, penable, pwrite, result_valid, rst_n} = '0;
    {paddr, pwdata, res_a, res_b, res_c, res_d} = '0;
    seed = 32'h43ECC4EC;
    lo = 12'h800;
    hi = 12'h7FF;
    mdl = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk_fl(alert_flags, 8'h00);
    rd_status();
    apb(1'b0, OFS_LOW, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0800);
    apb(1'b0, OFS_HIGH, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_07FF);
    apb(1'b0, 8'h40, 32'h0, 1'b0);
    chk_fl({7'h0, err}, 8'h01);
    $display("test reset done");
    r1 = xs();
    r2 = xs();
    lo = r1[THR_W-1:0];
    hi = r2[THR_W-1:0];
    apb(1'b1, OFS_LOW, {20'h0, lo}, 1'b0);
    apb(1'b1, OFS_HIGH, {20'h0, hi}, 1'b0);
    for (int i = 0; i < 256; i++) begin
      r1 = xs();
      r2 = xs();
      send(r1[0] | r1[1], r1[31:16], r1[15:0], r2[31:16], r2[15:0]);
      if (i % 8 == 7) begin
        settle();
        chk_fl(alert_flags, mdl);
        chk_fl({7'h0, irq}, 8'h00);
      end
      if (i % 32 == 31) rd_status();
    end
    rd_status();
    $display("test random done");
    lo = 12'h123;
    hi = 12'hABC;
    apb(1'b1, OFS_LOW, {20'h0, lo}, 1'b0);
    apb(1'b1, OFS_HIGH, {20'h0, hi}, 1'b0);
    for (int j = 0; j < 4; j++) begin
      send(1'b1, bnd(j), bnd(j + 1), bnd(j + 2), bnd(j + 3));
      settle();
      chk_fl(alert_flags, mdl);
      rd_status();
    end
    $display("test boundary done");
    send(1'b1, bnd(1), bnd(0), bnd(0), bnd(0));
    @(posedge clock);
    res_a <= bnd(3);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b1);
    chk_rd(rd, 32'h0000_0001);
    settle();
    chk_fl(alert_flags, 8'h02);
    mdl = 8'h02;
    rd_status();
    $display("test collision done");
    send(1'b1, bnd(1), bnd(1), bnd(1), bnd(1));
    apb(1'b1, OFS_STATUS, 32'hFF, 1'b0);
    settle();
    chk_fl(alert_flags, 8'h55);
    apb(1'b1, OFS_CFG2, 32'h3C, 1'b0);
    settle();
    chk_fl(alert_flags, 8'h00);
    apb(1'b0, OFS_LOW, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0123);
    mdl = '0;
    $display("test soft reset done");
    apb(1'b1, OFS_ISTAT, 32'hFF, 1'b0);
    apb(1'b1, OFS_IMASK, 32'h01, 1'b0);
    settle();
    chk_fl({7'h0, irq}, 8'h00);
    send(1'b1, bnd(1), bnd(0), bnd(0), bnd(0));
    settle();
    chk_fl({7'h0, irq}, 8'h01);
    apb(1'b1, OFS_IMASK, 32'h00, 1'b0);
    settle();
    chk_fl({7'h0, irq}, 8'h00);
    apb(1'b1, OFS_IMASK, 32'h01, 1'b0);
    settle();
    chk_fl({7'h0, irq}, 8'h01);
    apb(1'b1, OFS_ISTAT, 32'h01, 1'b0);
    settle();
    chk_fl({7'h0, irq}, 8'h00);
    rd_status();
    $display("test interrupt done");
    apb(1'b1, OFS_IMASK, 32'h03, 1'b0);
    send(1'b1, bnd(3), bnd(0), bnd(0), bnd(0));
    settle();
    chk_fl({7'h0, irq}, 8'h01);
    chk_fl(alert_flags, mdl);
    apb(1'b1, OFS_CFG2, {24'h0, CODE_HARD}, 1'b0);
    settle();
    chk_fl(alert_flags, 8'h00);
    chk_fl({7'h0, irq}, 8'h00);
    mdl = '0;
    lo = RST_LOW;
    hi = RST_HIGH;
    apb(1'b0, OFS_LOW, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0800);
    apb(1'b0, OFS_HIGH, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_07FF);
    apb(1'b0, OFS_IMASK, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0000);
    apb(1'b0, OFS_ISTAT, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0000);
    apb(1'b0, OFS_CFG2, 32'h0, 1'b0);
    chk_rd(rd, 32'h0000_0000);
    $display("test hard reset done");
    conclude();
  end
endmodule
`default_nettype wire
